// ### hw/smts_sched.sv
// master-mode transaction scheduler with apb registers
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module smts_sched
	import smts_pkg::*;
#(
	parameter int N          = NUM_ENTRIES,
	parameter int TICK_COUNT = TICK_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic        fb_online,
	output logic             tx_req,
	output logic [7:0]       tx_entry,
	output logic             tx_bcast,
	output logic [31:0]      tx_data,
	input  wire logic        tx_done,
	input  wire logic        rx_valid,
	input  wire logic [31:0] rx_data,
	output logic [11:0]      mem_addr,
	input  wire logic [7:0]  mem_rdata
);
	localparam int IW = $clog2(N);

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic                ctrl_reg;
	logic [IW-1:0]       sel_reg;
	logic [IRQ_W-1:0]    irq_stat_reg;
	logic [IRQ_W-1:0]    irq_mask_reg;
	logic [IRQ_W-1:0]    ev_reg;
	logic [31:0]         cfg_reg       [N];
	logic [15:0]         timeout_reg   [N];
	logic [15:0]         gap_reg       [N];
	logic [15:0]         recon_reg     [N];
	logic [11:0]         trig_addr_reg [N];
	logic [15:0]         update_reg    [N];
	logic [31:0]         out_reg       [N];
	logic [31:0]         frozen_reg    [N];
	logic [31:0]         in_reg        [N];
	logic [7:0]          last_trig_reg [N];
	logic [3:0]          to_cnt_reg    [N];
	logic [15:0]         upd_cnt_reg   [N];
	logic [15:0]         recon_cnt_reg [N];
	logic [N-1:0]        disc_reg;
	logic [N-1:0]        svc_pulse_reg;
	logic [N-1:0]        disc_pulse_reg;
	smts_state_type      state_reg;
	logic [IW-1:0]       idx_reg;
	logic [15:0]         timer_reg;
	logic                tick;
	logic                wr_en;
	logic                rd_setup;
	logic                mapped;
	logic                trig_ok;
	logic [31:0]         rdata_next;
	logic [31:0]         cur_cfg;
	logic                cur_bcast;
	logic [1:0]          cur_fbpol;
	logic                halted;
	logic                give_up;
	logic [IW-1:0]       idx_next;

	smts_tick #(.CYCLES(TICK_COUNT)) u_tick (
		.clock (clock),
		.rst_n (rst_n),
		.tick  (tick)
	);

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	assign wr_en    = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable;
	assign pready   = psel && penable;
	assign mapped   = (paddr[1:0] == 2'h0) && (paddr <= REG_IN_DATA);
	assign trig_ok  = ((pwdata[11:0] >= TRIG_LO1) && (pwdata[11:0] <= TRIG_HI1))
		|| ((pwdata[11:0] >= TRIG_LO2) && (pwdata[11:0] <= TRIG_HI2));

	always_comb begin
		rdata_next = 32'h0;
		case (paddr)
			REG_CTRL:      rdata_next[CTRL_RUN] = ctrl_reg;
			REG_STATUS: begin
				rdata_next[STAT_IDX +: IW]  = idx_reg;
				rdata_next[STAT_DISC +: N]  = disc_reg;
				rdata_next[STAT_BUSY]       = (state_reg != ST_IDLE);
				rdata_next[STAT_FB]         = fb_online;
			end
			REG_IRQ_STAT:  rdata_next[IRQ_W-1:0] = irq_stat_reg;
			REG_IRQ_MASK:  rdata_next[IRQ_W-1:0] = irq_mask_reg;
			REG_SEL:       rdata_next[IW-1:0] = sel_reg;
			REG_CFG:       rdata_next = cfg_reg[sel_reg];
			REG_TIMEOUT:   rdata_next[15:0] = timeout_reg[sel_reg];
			REG_GAP_RECON: rdata_next = {recon_reg[sel_reg], gap_reg[sel_reg]};
			REG_TRIG_ADDR: rdata_next[11:0] = trig_addr_reg[sel_reg];
			REG_UPDATE:    rdata_next[15:0] = update_reg[sel_reg];
			REG_OUT_DATA:  rdata_next = out_reg[sel_reg];
			REG_IN_DATA:   rdata_next = in_reg[sel_reg];
			default:       rdata_next = 32'h0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (rd_setup) begin
			prdata  <= pwrite ? 32'h0 : rdata_next;
			pslverr <= !mapped;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_reg     <= 1'b0;
			sel_reg      <= '0;
			irq_mask_reg <= '0;
		end else if (wr_en) begin
			if (paddr == REG_CTRL)
				ctrl_reg <= pwdata[CTRL_RUN];
			if (paddr == REG_SEL)
				sel_reg <= pwdata[IW-1:0];
			if (paddr == REG_IRQ_MASK)
				irq_mask_reg <= pwdata[IRQ_W-1:0];
		end
	end

	// per-entry settings written by software
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				cfg_reg[i]       <= CFG_RST;
				timeout_reg[i]   <= TIMEOUT_RST;
				gap_reg[i]       <= GAP_RST;
				recon_reg[i]     <= RECON_RST;
				trig_addr_reg[i] <= TRIG_ADR_RST;
				update_reg[i]    <= UPDATE_RST;
				out_reg[i]       <= 32'h0;
			end
		end else if (wr_en) begin
			case (paddr)
				REG_CFG:       cfg_reg[sel_reg] <= pwdata;
				REG_TIMEOUT:   timeout_reg[sel_reg] <= pwdata[15:0];
				REG_GAP_RECON: begin
					gap_reg[sel_reg]   <= pwdata[GAP_POS +: 16];
					recon_reg[sel_reg] <= pwdata[RECON_POS +: 16];
				end
				REG_TRIG_ADDR: if (trig_ok) begin
					trig_addr_reg[sel_reg] <= pwdata[11:0];
				end
				REG_UPDATE:    update_reg[sel_reg] <= pwdata[15:0];
				REG_OUT_DATA:  out_reg[sel_reg] <= pwdata;
				default:       ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n)
			irq_stat_reg <= '0;
		else
			irq_stat_reg <= (irq_stat_reg
				& ~((wr_en && paddr == REG_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0))
				| ev_reg;
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(irq_stat_reg & irq_mask_reg);
	end

	// ----------------------------------------------------------------
	// per-entry timers and frozen copies
	// ----------------------------------------------------------------
	for (genvar g = 0; g < N; g++) begin : g_entry
		always_ff @(posedge clock) begin
			if (!rst_n)
				upd_cnt_reg[g] <= 16'h0;
			else if (svc_pulse_reg[g])
				upd_cnt_reg[g] <= update_reg[g];
			else if (tick && upd_cnt_reg[g] != 16'h0)
				upd_cnt_reg[g] <= upd_cnt_reg[g] - 16'h1;
		end

		always_ff @(posedge clock) begin
			if (!rst_n)
				recon_cnt_reg[g] <= 16'h0;
			else if (disc_pulse_reg[g])
				recon_cnt_reg[g] <= recon_reg[g];
			else if (tick && recon_cnt_reg[g] != 16'h0)
				recon_cnt_reg[g] <= recon_cnt_reg[g] - 16'h1;
		end

		always_ff @(posedge clock) begin
			if (!rst_n)
				frozen_reg[g] <= 32'h0;
			else if (fb_online)
				frozen_reg[g] <= out_reg[g];
		end
	end

	// ----------------------------------------------------------------
	// scheduler
	// ----------------------------------------------------------------
	assign cur_cfg   = cfg_reg[idx_reg];
	assign cur_bcast = cur_cfg[CFG_BCAST];
	assign cur_fbpol = cur_cfg[CFG_FBPOL +: 2];
	assign halted    = !fb_online && (cur_fbpol == FB_HALT);
	assign give_up   = ({1'b0, to_cnt_reg[idx_reg]} + 5'h1) >= {1'b0, cur_cfg[CFG_RETRY +: 4]};
	assign idx_next  = (idx_reg == IW'(N - 1)) ? '0 : idx_reg + IW'(1);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg      <= ST_IDLE;
			idx_reg        <= '0;
			timer_reg      <= 16'h0;
			tx_req         <= 1'b0;
			tx_entry       <= 8'h0;
			tx_bcast       <= 1'b0;
			tx_data        <= 32'h0;
			mem_addr       <= 12'h0;
			disc_reg       <= '0;
			svc_pulse_reg  <= '0;
			disc_pulse_reg <= '0;
			ev_reg         <= '0;
			for (int i = 0; i < N; i++) begin
				in_reg[i]        <= 32'h0;
				last_trig_reg[i] <= 8'h0;
				to_cnt_reg[i]    <= 4'h0;
			end
		end else begin
			tx_req         <= 1'b0;
			svc_pulse_reg  <= '0;
			disc_pulse_reg <= '0;
			ev_reg         <= '0;
			case (state_reg)
				ST_IDLE: if (ctrl_reg) begin
					state_reg <= ST_PICK;
				end
				ST_PICK: begin
					if (!ctrl_reg) begin
						state_reg <= ST_IDLE;
					end else if (!cur_cfg[CFG_VALID] || upd_cnt_reg[idx_reg] != 16'h0
						|| halted) begin
						idx_reg <= idx_next;
					end else if (!cur_bcast && disc_reg[idx_reg]
						&& recon_cnt_reg[idx_reg] != 16'h0) begin
						idx_reg <= idx_next;
					end else if (cur_cfg[CFG_TRIG]) begin
						mem_addr  <= trig_addr_reg[idx_reg];
						state_reg <= ST_TRIG_RD;
					end else begin
						state_reg <= ST_SEND;
					end
				end
				ST_TRIG_RD: state_reg <= ST_TRIG_CHK;
				ST_TRIG_CHK: begin
					svc_pulse_reg[idx_reg] <= 1'b1;
					if (mem_rdata != last_trig_reg[idx_reg]) begin
						last_trig_reg[idx_reg] <= mem_rdata;
						state_reg              <= ST_SEND;
					end else begin
						idx_reg   <= idx_next;
						state_reg <= ST_PICK;
					end
				end
				ST_SEND: begin
					if (halted) begin
						idx_reg   <= idx_next;
						state_reg <= ST_PICK;
					end else begin
						tx_req                 <= 1'b1;
						tx_entry               <= 8'(idx_reg);
						tx_bcast               <= cur_bcast;
						svc_pulse_reg[idx_reg] <= 1'b1;
						if (fb_online)
							tx_data <= out_reg[idx_reg];
						else if (cur_fbpol == FB_CLEAR)
							tx_data <= 32'h0;
						else
							tx_data <= frozen_reg[idx_reg];
						if (disc_reg[idx_reg]) begin
							disc_reg[idx_reg] <= 1'b0;
							ev_reg[IRQ_RECON] <= 1'b1;
						end
						state_reg <= ST_TX_WAIT;
					end
				end
				ST_TX_WAIT: if (tx_done) begin
					if (cur_bcast) begin
						timer_reg <= gap_reg[idx_reg];
						state_reg <= ST_GAP;
					end else begin
						timer_reg <= timeout_reg[idx_reg];
						state_reg <= ST_RESP_WAIT;
					end
				end
				ST_RESP_WAIT: begin
					if (rx_valid) begin
						in_reg[idx_reg]     <= rx_data;
						to_cnt_reg[idx_reg] <= 4'h0;
						ev_reg[IRQ_RESP]    <= 1'b1;
						idx_reg             <= idx_next;
						state_reg           <= ST_PICK;
					end else if (timer_reg == 16'h0) begin
						ev_reg[IRQ_TMO] <= 1'b1;
						if (give_up) begin
							to_cnt_reg[idx_reg]     <= 4'h0;
							disc_reg[idx_reg]       <= 1'b1;
							disc_pulse_reg[idx_reg] <= 1'b1;
							ev_reg[IRQ_DISC]        <= 1'b1;
							if (cur_cfg[CFG_SNPOL] == SN_CLEAR)
								in_reg[idx_reg] <= 32'h0;
							idx_reg   <= idx_next;
							state_reg <= ST_PICK;
						end else begin
							to_cnt_reg[idx_reg] <= to_cnt_reg[idx_reg] + 4'h1;
							state_reg           <= ST_SEND;
						end
					end else if (tick) begin
						timer_reg <= timer_reg - 16'h1;
					end
				end
				ST_GAP: begin
					if (timer_reg == 16'h0) begin
						idx_reg   <= idx_next;
						state_reg <= ST_PICK;
					end else if (tick) begin
						timer_reg <= timer_reg - 16'h1;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	gap_hold_a: assert property (
		(state_reg == ST_GAP && timer_reg != 16'h0) |=> (state_reg == ST_GAP && !tx_req))
		else $error("broadcast gap cut short");
	tick_step_a: assert property (
		(state_reg == ST_RESP_WAIT && !rx_valid && timer_reg != 16'h0)
		|=> timer_reg == ($past(timer_reg) - {15'h0, $past(tick)}))
		else $error("timeout timer not counting ticks");
	timeout_load_a: assert property (
		(state_reg == ST_TX_WAIT && tx_done && !cur_bcast)
		|=> (state_reg == ST_RESP_WAIT && timer_reg == timeout_reg[idx_reg]))
		else $error("timeout not loaded after query");
	retransmit_a: assert property (
		(state_reg == ST_RESP_WAIT && !rx_valid && timer_reg == 16'h0 && !give_up)
		|=> state_reg == ST_SEND ##1 (tx_req || !fb_online))
		else $error("query not retransmitted");
	disconnect_a: assert property (
		(state_reg == ST_RESP_WAIT && !rx_valid && timer_reg == 16'h0 && give_up)
		|=> (disc_reg[$past(idx_reg)] && disc_pulse_reg[$past(idx_reg)]))
		else $error("node not disconnected at retry limit");
	recon_wait_a: assert property (
		(state_reg == ST_SEND && disc_reg[idx_reg]) |-> recon_cnt_reg[idx_reg] == 16'h0)
		else $error("disconnected node addressed early");
	bcast_path_a: assert property (
		(state_reg == ST_TX_WAIT && tx_done && cur_bcast) |=> state_reg == ST_GAP)
		else $error("broadcast awaited a response");
	halt_send_a: assert property (
		tx_req |-> ($past(fb_online) || $past(cur_fbpol) != FB_HALT))
		else $error("transmitted while halted");
	clear_data_a: assert property (
		(tx_req && !$past(fb_online) && $past(cur_fbpol) == FB_CLEAR) |-> tx_data == 32'h0)
		else $error("offline clear sent nonzero data");
	trig_range_a: assert property (
		trig_addr_reg[sel_reg] >= TRIG_LO1)
		else $error("trigger address out of range");
	trig_send_a: assert property (
		(state_reg == ST_TRIG_CHK && mem_rdata != last_trig_reg[idx_reg])
		|=> state_reg == ST_SEND)
		else $error("trigger change did not start query");
	resp_clear_a: assert property (
		(state_reg == ST_RESP_WAIT && rx_valid)
		|=> (to_cnt_reg[$past(idx_reg)] == 4'h0 && state_reg == ST_PICK))
		else $error("response did not clear timeout count");
endmodule : smts_sched
`default_nettype wire

// ### hw/smts_tick.sv
// prescaler producing the 10 ms scheduling tick
`timescale 1ns/10ps
`default_nettype none
module smts_tick #(
	parameter int CYCLES = 100000
) (
	input  wire logic clock,
	input  wire logic rst_n,
	output logic      tick
);
	logic [31:0] cnt_reg;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cnt_reg <= 32'h0;
			tick    <= 1'b0;
		end else if (cnt_reg == 32'(CYCLES - 1)) begin
			cnt_reg <= 32'h0;
			tick    <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 32'h1;
			tick    <= 1'b0;
		end
	end
endmodule : smts_tick
`default_nettype wire

// ### include/smts_pkg.sv
// shared constants and types of the serial master transaction scheduler
package smts_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ      = 10_000_000;
	localparam int TICK_MS     = 10;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int NUM_ENTRIES = 8;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] REG_CTRL      = 12'h000;
	localparam logic [11:0] REG_STATUS    = 12'h004;
	localparam logic [11:0] REG_IRQ_STAT  = 12'h008;
	localparam logic [11:0] REG_IRQ_MASK  = 12'h00C;
	localparam logic [11:0] REG_SEL       = 12'h010;
	localparam logic [11:0] REG_CFG       = 12'h014;
	localparam logic [11:0] REG_TIMEOUT   = 12'h018;
	localparam logic [11:0] REG_GAP_RECON = 12'h01C;
	localparam logic [11:0] REG_TRIG_ADDR = 12'h020;
	localparam logic [11:0] REG_UPDATE    = 12'h024;
	localparam logic [11:0] REG_OUT_DATA  = 12'h028;
	localparam logic [11:0] REG_IN_DATA   = 12'h02C;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_RUN   = 0;
	localparam int CFG_VALID  = 0;
	localparam int CFG_BCAST  = 1;
	localparam int CFG_TRIG   = 2;
	localparam int CFG_FBPOL  = 3;
	localparam int CFG_SNPOL  = 5;
	localparam int CFG_RETRY  = 8;
	localparam int STAT_IDX   = 0;
	localparam int STAT_DISC  = 8;
	localparam int STAT_BUSY  = 30;
	localparam int STAT_FB    = 31;
	localparam int GAP_POS    = 0;
	localparam int RECON_POS  = 16;
	localparam int IRQ_TMO    = 0;
	localparam int IRQ_DISC   = 1;
	localparam int IRQ_RECON  = 2;
	localparam int IRQ_RESP   = 3;
	localparam int IRQ_BADADR = 4;
	localparam int IRQ_W      = 5;
	// ----------------------------------------------------------------
	// encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0]  FB_CLEAR     = 2'h0;
	localparam logic [1:0]  FB_FREEZE    = 2'h1;
	localparam logic [1:0]  FB_HALT      = 2'h2;
	localparam logic        SN_CLEAR     = 1'h0;
	localparam logic [11:0] TRIG_LO1     = 12'h200;
	localparam logic [11:0] TRIG_HI1     = 12'h3FF;
	localparam logic [11:0] TRIG_LO2     = 12'h400;
	localparam logic [11:0] TRIG_HI2     = 12'hFFF;
	localparam logic [31:0] CFG_RST      = 32'h0000_0300;
	localparam logic [15:0] TIMEOUT_RST  = 16'h0064;
	localparam logic [15:0] GAP_RST      = 16'h0064;
	localparam logic [15:0] RECON_RST    = 16'h03E8;
	localparam logic [15:0] UPDATE_RST   = 16'h0064;
	localparam logic [11:0] TRIG_ADR_RST = 12'h5FF;

	typedef enum {ST_IDLE, ST_PICK, ST_TRIG_RD, ST_TRIG_CHK, ST_SEND, ST_TX_WAIT,
		ST_RESP_WAIT, ST_GAP} smts_state_type;
endpackage : smts_pkg

// ### sim/serial_master_txn_scheduler_bench.sv
// self-checking bench of the transaction scheduler
`timescale 1ns/10ps
`default_nettype none
module serial_master_txn_scheduler_bench;
	import smts_pkg::*;
	localparam int          TK   = 8;
	localparam logic [31:0] RESP = 32'h5A5A_0F0F;
	logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, irq, e;
	logic        fb_online, tx_req, tx_bcast, tx_done, rx_valid, respond, slow;
	logic [11:0] paddr, mem_addr, t;
	logic [31:0] pwdata, prdata, tx_data, rx_data, q;
	logic [7:0]  tx_entry, trig_byte;
	int          n_mismatch, total_checks, n_tx, c, b;

	smts_sched #(.TICK_COUNT(TK)) uut (.clock(clock), .rst_n(rst_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.fb_online(fb_online), .tx_req(tx_req), .tx_entry(tx_entry),
		.tx_bcast(tx_bcast), .tx_data(tx_data), .tx_done(tx_done),
		.rx_valid(rx_valid), .rx_data(rx_data), .mem_addr(mem_addr),
		.mem_rdata(trig_byte));

	smts_slave_model #(.RESP(RESP)) model (.clock(clock), .tx_req(tx_req),
		.tx_bcast(tx_bcast), .respond(respond), .slow(slow), .tx_done(tx_done),
		.rx_valid(rx_valid), .rx_data(rx_data));

	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end

	always @(posedge clock) if (tx_req === 1'h1) n_tx <= n_tx + 1;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize

	task automatic hang;
		n_mismatch++;
		$display("FAIL t=%0t wait bound used up", $time);
		summarize();
	endtask : hang

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'h1 && n < 16);
		if (pready !== 1'h1) hang();
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic wait_tx;
		c = 0;
		do begin
			@(posedge clock);
			c++;
			if (c > 3000) hang();
		end while (tx_req !== 1'h1);
	endtask : wait_tx

	task automatic stop_run;
		apb(1'h1, REG_CTRL, 32'h0);
		b = 0;
		do begin
			apb(1'h0, REG_STATUS, 32'h0);
			b++;
			if (b > 300) hang();
		end while (q[STAT_BUSY] !== 1'h0);
	endtask : stop_run

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic test_reset;
		chk({31'h0, irq}, 32'h0);
		apb(1'h0, REG_CFG, 32'h0);
		chk(q, CFG_RST);
		apb(1'h0, REG_TIMEOUT, 32'h0);
		chk(q, {16'h0, TIMEOUT_RST});
		apb(1'h0, REG_GAP_RECON, 32'h0);
		chk(q, {RECON_RST, GAP_RST});
		apb(1'h0, 12'h030, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("test reset done");
	endtask : test_reset

	task automatic test_trig;
		logic [11:0] v[5];
		logic [11:0] x;
		v = '{12'h1FF, 12'h200, 12'h3FF, 12'h0FF, 12'h400};
		x = TRIG_ADR_RST;
		foreach (v[i]) begin
			t = v[i];
			apb(1'h1, REG_TRIG_ADDR, {20'h0, t});
			if ((t >= TRIG_LO1 && t <= TRIG_HI1) || (t >= TRIG_LO2 && t <= TRIG_HI2)) x = t;
			apb(1'h0, REG_TRIG_ADDR, 32'h0);
			chk(q, {20'h0, x});
		end
		$display("test trigger address done");
	endtask : test_trig

	task automatic test_query;
		slow <= 1'h1;
		apb(1'h1, REG_SEL, 32'h0);
		apb(1'h1, REG_CFG, 32'h301);
		apb(1'h1, REG_TIMEOUT, 32'h4);
		apb(1'h1, REG_UPDATE, 32'h0);
		apb(1'h1, REG_OUT_DATA, 32'hCAFE_0001);
		apb(1'h1, REG_IRQ_MASK, 32'h8);
		apb(1'h1, REG_CTRL, 32'h1);
		wait_tx();
		chk(tx_data, 32'hCAFE_0001);
		chk({23'h0, tx_bcast, tx_entry}, 32'h0);
		wait_tx();
		apb(1'h0, REG_IN_DATA, 32'h0);
		chk(q, RESP);
		apb(1'h0, REG_IRQ_STAT, 32'h0);
		chk({31'h0, q[IRQ_RESP]}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		fb_online <= 1'h0;
		wait_tx();
		wait_tx();
		chk(tx_data, 32'h0);
		fb_online <= 1'h1;
		stop_run();
		apb(1'h1, REG_IRQ_STAT, 32'hFF);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h0);
		$display("test query done");
	endtask : test_query

	task automatic test_disc;
		respond <= 1'h0;
		slow <= 1'h0;
		apb(1'h1, REG_CFG, 32'h201);
		apb(1'h1, REG_TIMEOUT, 32'h2);
		apb(1'h1, REG_GAP_RECON, 32'h0003_0004);
		b = n_tx;
		apb(1'h1, REG_CTRL, 32'h1);
		c = 0;
		do begin
			apb(1'h0, REG_STATUS, 32'h0);
			c++;
			if (c > 200) hang();
		end while (q[STAT_DISC] !== 1'h1);
		chk(32'(n_tx - b), 32'h2);
		apb(1'h0, REG_IN_DATA, 32'h0);
		chk(q, 32'h0);
		wait_tx();
		chk({31'h0, c >= 10 && c <= 30}, 32'h1);
		stop_run();
		$display("test disconnect done");
	endtask : test_disc

	task automatic test_bcast;
		apb(1'h1, REG_CFG, 32'h0);
		apb(1'h1, REG_SEL, 32'h1);
		apb(1'h1, REG_CFG, 32'h3);
		apb(1'h1, REG_UPDATE, 32'h0);
		apb(1'h1, REG_GAP_RECON, 32'h0003_0004);
		apb(1'h1, REG_CTRL, 32'h1);
		wait_tx();
		chk({23'h0, tx_bcast, tx_entry}, 32'h101);
		wait_tx();
		// four-tick gap, first tick partial, plus fixed turnaround
		chk({31'h0, c >= 3 * TK + 14 && c <= 4 * TK + 13}, 32'h1);
		wait_tx();
		apb(1'h0, REG_STATUS, 32'h0);
		// entry 0 still disconnected from the previous test
		chk({24'h0, q[15:8]}, 32'h1);
		$display("test broadcast done");
	endtask : test_bcast

	task automatic test_trig_mode;
		stop_run();
		apb(1'h1, REG_CFG, 32'h0);
		apb(1'h1, REG_SEL, 32'h2);
		apb(1'h1, REG_CFG, 32'h315);
		apb(1'h1, REG_UPDATE, 32'h0);
		apb(1'h1, REG_TRIG_ADDR, {20'h0, TRIG_LO2});
		respond <= 1'h1;
		fb_online <= 1'h0;
		trig_byte <= 8'h01;
		b = n_tx;
		apb(1'h1, REG_CTRL, 32'h1);
		repeat (60) @(posedge clock);
		chk(32'(n_tx - b), 32'h0);
		fb_online <= 1'h1;
		wait_tx();
		chk({24'h0, tx_entry}, 32'h2);
		chk({20'h0, mem_addr}, {20'h0, TRIG_LO2});
		repeat (100) @(posedge clock);
		chk(32'(n_tx - b), 32'h1);
		stop_run();
		$display("test trigger mode done");
	endtask : test_trig_mode

	initial begin
		rst_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		fb_online = 1'h1;
		respond = 1'h1;
		slow = 1'h0;
		trig_byte = 8'h00;
		n_tx = 0;
		n_mismatch = 0;
		total_checks = 0;
		repeat (2) @(posedge clock);
		rst_n <= 1'h1;
		test_reset();
		test_trig();
		test_query();
		test_disc();
		test_bcast();
		test_trig_mode();
		summarize();
	end
endmodule : serial_master_txn_scheduler_bench
`default_nettype wire

// ### sim/smts_slave_model.sv
// serial slave model answering scheduler transmissions
`timescale 1ns/10ps
`default_nettype none
module smts_slave_model #(
	parameter logic [31:0] RESP = 32'h5A5A_0F0F
) (
	input  wire logic   clock,
	input  wire logic   tx_req,
	input  wire logic   tx_bcast,
	input  wire logic   respond,
	input  wire logic   slow,
	output logic        tx_done,
	output logic        rx_valid,
	output logic [31:0] rx_data
);
	// ----------------------------------------------------------------
	// one transaction at a time
	// ----------------------------------------------------------------
	logic bc;
	initial begin
		tx_done = 1'h0;
		rx_valid = 1'h0;
		rx_data = ~RESP;
		forever begin
			@(posedge clock);
			if (tx_req) begin
				bc = tx_bcast;
				repeat (slow ? 6 : 1) @(posedge clock);
				tx_done <= 1'h1;
				@(posedge clock);
				tx_done <= 1'h0;
				// broadcast gets no answer
				if (!bc && respond) begin
					repeat (2) @(posedge clock);
					rx_valid <= 1'h1;
					rx_data <= RESP;
					@(posedge clock);
					rx_valid <= 1'h0;
					rx_data <= ~RESP;
				end
			end
		end
	end
endmodule : smts_slave_model
`default_nettype wire
